// ### rtl/ald_alu_logic.sv
// data alu logic unit with accumulators, data registers and division range check
//
// What this block does
// - fractional quotient must lie from -1.0 to below 1.0 minus one step
// - fractional division with dividend larger than divisor always overflows
// - integer quotient must fit the signed 16-bit range
// - a quotient that does not fit its destination is flagged as overflow
// - logic operations exist for 16-bit and 32-bit operands
// - logic operations use raw bits, integer or fractional alike
// - 16-bit operations use accumulator middle word or a 16-bit data register
// - 32-bit operations use accumulator middle and low words or the register pair
// - and, or, exclusive-or exist at both widths
// - inversion exists only for 16-bit operands
// - accumulator is 4-bit extension, 16-bit middle word, 16-bit low word
`timescale 1ns/100ps
module ald_alu_logic
	import ald_pkg::*;
(
	// clock, reset, enable
	input  wire logic                    mclk_i,
	input  wire logic                    arst_n_i,
	input  wire logic                    ce_i,
	// register load port
	input  wire logic                    ld_valid_i,
	input  wire ald_ld_e                 ld_sel_i,
	input  wire logic [ACC_W-1:0]        ld_data_i,
	// logic operation request
	input  wire logic                    op_valid_i,
	input  wire ald_lop_e                op_code_i,
	input  wire logic                    op_long_i,
	input  wire ald_src_e                op_src_i,
	input  wire logic                    op_dst_b_i,
	output logic                         op_done_o,
	output logic                         op_illegal_o,
	// register contents
	output logic [ACC_W-1:0]             acc_a_o,
	output logic [ACC_W-1:0]             acc_b_o,
	output logic [WORD_W-1:0]            data_reg_x_low_o,
	output logic [WORD_W-1:0]            data_reg_y_low_o,
	output logic [WORD_W-1:0]            data_reg_y_high_o,
	// division range check
	input  wire logic                    div_req_i,
	input  wire logic                    div_frac_i,
	input  wire logic signed [DVD_W-1:0] div_dividend_i,
	input  wire logic signed [WORD_W-1:0] div_divisor_i,
	input  wire logic signed [QUO_W-1:0] div_quotient_i,
	output logic                         div_done_o,
	output logic                         div_ovf_o
);

	// one bitwise operator for either width, format blind
	function automatic logic [LONG_W-1:0] lop_f(input ald_lop_e op,
		input logic [LONG_W-1:0] d, input logic [LONG_W-1:0] s);
		case (op)
			LOP_AND: lop_f = d & s;
			LOP_OR:  lop_f = d | s;
			LOP_XOR: lop_f = d ^ s;
			LOP_NOT: lop_f = ~d;
			default: lop_f = d;
		endcase
	endfunction : lop_f

	logic [ACC_W-1:0]  acc_a_reg;
	logic [ACC_W-1:0]  acc_b_reg;
	logic [WORD_W-1:0] x_low_reg;
	logic [WORD_W-1:0] y_low_reg;
	logic [WORD_W-1:0] y_high_reg;
	logic              done_reg;
	logic              illegal_reg;

	logic [ACC_W-1:0]  dst_acc;
	logic [ACC_W-1:0]  oth_acc;
	logic [WORD_W-1:0] src_word;
	logic [LONG_W-1:0] src_long;
	logic [LONG_W-1:0] res_word_full;
	logic [LONG_W-1:0] res_long;
	logic [ACC_W-1:0]  acc_next;
	logic              illegal;
	logic              exec;
	logic              ld_take;

	assign dst_acc = op_dst_b_i ? acc_b_reg : acc_a_reg;
	assign oth_acc = op_dst_b_i ? acc_a_reg : acc_b_reg;

	// source operand selection
	always_comb begin
		src_word = WORD_RST;
		src_long = {WORD_RST, WORD_RST};
		case (op_src_i)
			SRC_X_LOW:     src_word = x_low_reg;
			SRC_Y_LOW:     src_word = y_low_reg;
			SRC_Y_HIGH:    src_word = y_high_reg;
			SRC_Y_PAIR:    src_long = {y_high_reg, y_low_reg};
			SRC_ACC_OTHER: begin
				src_word = oth_acc[ACC_MID_MSB:ACC_MID_LSB];
				src_long = oth_acc[ACC_MID_MSB:ACC_LOW_LSB];
			end
			default: begin
				src_word = WORD_RST;
				src_long = {WORD_RST, WORD_RST};
			end
		endcase
	end

	// width, operation and source combinations that do not exist
	always_comb begin
		illegal = 1'b0;
		if (op_long_i) begin
			if (op_code_i == LOP_NOT) begin
				illegal = 1'b1;
			end
			if (op_src_i != SRC_Y_PAIR && op_src_i != SRC_ACC_OTHER) begin
				illegal = 1'b1;
			end
		end else if (op_src_i == SRC_Y_PAIR) begin
			illegal = 1'b1;
		end
	end

	assign exec    = ce_i && op_valid_i && !illegal;
	assign ld_take = ce_i && ld_valid_i && !op_valid_i;

	// results: word result in the middle word, long result over middle and low
	assign res_word_full = lop_f(op_code_i, {WORD_RST, dst_acc[ACC_MID_MSB:ACC_MID_LSB]},
		{WORD_RST, src_word});
	assign res_long = lop_f(op_code_i, dst_acc[ACC_MID_MSB:ACC_LOW_LSB], src_long);

	always_comb begin
		acc_next = dst_acc;
		if (op_long_i) begin
			acc_next[ACC_MID_MSB:ACC_LOW_LSB] = res_long;
		end else begin
			acc_next[ACC_MID_MSB:ACC_MID_LSB] = res_word_full[WORD_W-1:0];
		end
	end

	// accumulator a
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			acc_a_reg <= ACC_RST;
		end else if (exec && !op_dst_b_i) begin
			acc_a_reg <= acc_next;
		end else if (ld_take && ld_sel_i == LD_ACC_A) begin
			acc_a_reg <= ld_data_i;
		end
	end

	// accumulator b
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			acc_b_reg <= ACC_RST;
		end else if (exec && op_dst_b_i) begin
			acc_b_reg <= acc_next;
		end else if (ld_take && ld_sel_i == LD_ACC_B) begin
			acc_b_reg <= ld_data_i;
		end
	end

	// 16-bit data registers
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			x_low_reg  <= WORD_RST;
			y_low_reg  <= WORD_RST;
			y_high_reg <= WORD_RST;
		end else if (ld_take) begin
			case (ld_sel_i)
				LD_X_LOW:  x_low_reg  <= ld_data_i[ACC_LOW_MSB:ACC_LOW_LSB];
				LD_Y_LOW:  y_low_reg  <= ld_data_i[ACC_LOW_MSB:ACC_LOW_LSB];
				LD_Y_HIGH: y_high_reg <= ld_data_i[ACC_LOW_MSB:ACC_LOW_LSB];
				default:   x_low_reg  <= x_low_reg;
			endcase
		end
	end

	// completion and refusal pulses
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			done_reg    <= 1'b0;
			illegal_reg <= 1'b0;
		end else if (ce_i) begin
			done_reg    <= op_valid_i && !illegal;
			illegal_reg <= op_valid_i && illegal;
		end
	end

	assign acc_a_o           = acc_a_reg;
	assign acc_b_o           = acc_b_reg;
	assign data_reg_x_low_o  = x_low_reg;
	assign data_reg_y_low_o  = y_low_reg;
	assign data_reg_y_high_o = y_high_reg;
	assign op_done_o         = done_reg;
	assign op_illegal_o      = illegal_reg;

	// division range check
	ald_div_if div_bus ();

	assign div_bus.req      = div_req_i;
	assign div_bus.frac     = div_frac_i;
	assign div_bus.dividend = div_dividend_i;
	assign div_bus.divisor  = div_divisor_i;
	assign div_bus.quotient = div_quotient_i;
	assign div_done_o       = div_bus.done;
	assign div_ovf_o        = div_bus.ovf;

	ald_div_range u_div_range (
		.mclk_i   (mclk_i),
		.arst_n_i (arst_n_i),
		.ce_i     (ce_i),
		.div      (div_bus.chk)
	);

	default clocking dcb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	a_not_long_refused: assert property (ce_i && op_valid_i && op_long_i
		&& op_code_i == LOP_NOT |=> op_illegal_o && !op_done_o && $stable(acc_a_o)
		&& $stable(acc_b_o))
		else $error("long inversion was not refused");
	a_and_word_x: assert property (ce_i && op_valid_i && !op_long_i && !op_dst_b_i
		&& op_code_i == LOP_AND && op_src_i == SRC_X_LOW
		|=> acc_a_o[31:16] == ($past(acc_a_o[31:16]) & $past(data_reg_x_low_o)))
		else $error("word and with x register wrong");
	a_xor_long_pair: assert property (ce_i && op_valid_i && op_long_i && !op_dst_b_i
		&& op_code_i == LOP_XOR && op_src_i == SRC_Y_PAIR
		|=> acc_a_o[31:0] == ($past(acc_a_o[31:0])
		^ {$past(data_reg_y_high_o), $past(data_reg_y_low_o)}))
		else $error("long exclusive-or with register pair wrong");
	a_ext_untouched: assert property (exec |=> $stable(acc_a_o[35:32])
		&& $stable(acc_b_o[35:32]))
		else $error("logic operation changed an extension");
	a_word_low_kept: assert property (exec && !op_long_i
		|=> $stable(acc_a_o[15:0]) && $stable(acc_b_o[15:0]))
		else $error("word operation changed a low word");
	a_or_word_b: assert property (ce_i && op_valid_i && !op_long_i && op_dst_b_i
		&& op_code_i == LOP_OR && op_src_i == SRC_Y_HIGH
		|=> acc_b_o[31:16] == ($past(acc_b_o[31:16]) | $past(data_reg_y_high_o)))
		else $error("word or on accumulator b wrong");
	a_narrow_long_src: assert property (ce_i && op_valid_i && op_long_i
		&& op_src_i == SRC_X_LOW |=> op_illegal_o ##1 (!op_illegal_o || $past(op_valid_i)))
		else $error("long operation on a word register accepted");
	a_long_and_other: assert property (ce_i && op_valid_i && op_long_i && op_dst_b_i
		&& op_code_i == LOP_AND && op_src_i == SRC_ACC_OTHER
		|=> acc_b_o[31:0] == ($past(acc_b_o[31:0]) & $past(acc_a_o[31:0])) && op_done_o)
		else $error("long and between accumulators wrong");

	c_word_not: cover property (exec && !op_long_i && op_code_i == LOP_NOT);
	c_long_xor: cover property (exec && op_long_i && op_code_i == LOP_XOR);
	c_refused: cover property (op_illegal_o);

endmodule : ald_alu_logic

// ### pkg/ald_pkg.sv
// shared constants and types for the alu logic and division range block
package ald_pkg;

	// operand widths
	localparam int ACC_W  = 36;
	localparam int LONG_W = 32;
	localparam int WORD_W = 16;
	localparam int EXT_W  = 4;
	localparam int DVD_W  = 32;
	localparam int QUO_W  = 36;
	localparam int MAG_W  = 48;

	// accumulator field positions
	localparam int ACC_EXT_MSB = 35;
	localparam int ACC_EXT_LSB = 32;
	localparam int ACC_MID_MSB = 31;
	localparam int ACC_MID_LSB = 16;
	localparam int ACC_LOW_MSB = 15;
	localparam int ACC_LOW_LSB = 0;

	// reset values
	localparam logic [35:0] ACC_RST  = 36'h0_0000_0000;
	localparam logic [15:0] WORD_RST = 16'h0000;

	// quotient limits, fractional quotient counted in steps of 2^-15
	localparam logic signed [35:0] FRAC_Q_MIN = 36'shF_FFFF_8000;
	localparam logic signed [35:0] FRAC_Q_MAX = 36'sh0_0000_7FFE;
	localparam logic signed [35:0] INT_Q_MIN  = 36'shF_FFFF_8000;
	localparam logic signed [35:0] INT_Q_MAX  = 36'sh0_0000_7FFF;

	typedef enum logic [1:0] {
		LOP_AND,
		LOP_OR,
		LOP_XOR,
		LOP_NOT
	} ald_lop_e;

	typedef enum logic [2:0] {
		SRC_X_LOW,
		SRC_Y_LOW,
		SRC_Y_HIGH,
		SRC_Y_PAIR,
		SRC_ACC_OTHER
	} ald_src_e;

	typedef enum logic [2:0] {
		LD_X_LOW,
		LD_Y_LOW,
		LD_Y_HIGH,
		LD_ACC_A,
		LD_ACC_B
	} ald_ld_e;

endpackage : ald_pkg

// ### pkg/ald_div_if.sv
// division range check request and verdict between core and checker
`timescale 1ns/100ps
interface ald_div_if;
	import ald_pkg::*;

	logic                    req;
	logic                    frac;
	logic signed [DVD_W-1:0] dividend;
	logic signed [WORD_W-1:0] divisor;
	logic signed [QUO_W-1:0] quotient;
	logic                    done;
	logic                    ovf;

	modport core (output req, output frac, output dividend, output divisor,
		output quotient, input done, input ovf);
	modport chk (input req, input frac, input dividend, input divisor,
		input quotient, output done, output ovf);

endinterface : ald_div_if

// ### rtl/ald_div_range.sv
// division overflow range checker
`timescale 1ns/100ps
module ald_div_range
	import ald_pkg::*;
(
	// clock, reset, enable
	input  wire logic mclk_i,
	input  wire logic arst_n_i,
	input  wire logic ce_i,
	// request and verdict
	ald_div_if.chk    div
);

	function automatic logic [MAG_W-1:0] mag_f(input logic signed [MAG_W-1:0] v);
		mag_f = v[MAG_W-1] ? MAG_W'(-v) : MAG_W'(v);
	endfunction : mag_f

	logic signed [MAG_W-1:0] dvd_ext;
	logic signed [MAG_W-1:0] dvs_ext;
	logic                    mag_big;
	logic                    frac_out;
	logic                    int_out;
	logic                    ovf_next;
	logic                    done_reg;
	logic                    ovf_reg;

	// divisor aligned to the dividend's binary point
	assign dvd_ext  = {{(MAG_W-DVD_W){div.dividend[DVD_W-1]}}, div.dividend};
	assign dvs_ext  = {{(MAG_W-DVD_W){div.divisor[WORD_W-1]}}, div.divisor, WORD_RST};
	assign mag_big  = mag_f(dvd_ext) > mag_f(dvs_ext);
	assign frac_out = (div.quotient < FRAC_Q_MIN) || (div.quotient > FRAC_Q_MAX);
	assign int_out  = (div.quotient < INT_Q_MIN) || (div.quotient > INT_Q_MAX);
	assign ovf_next = div.frac ? (frac_out || mag_big) : int_out;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			done_reg <= 1'b0;
			ovf_reg  <= 1'b0;
		end else if (ce_i) begin
			done_reg <= div.req;
			if (div.req) begin
				ovf_reg <= ovf_next;
			end
		end
	end

	assign div.done = done_reg;
	assign div.ovf  = ovf_reg;

	default clocking dcb @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);

	a_frac_in_range: assert property (ce_i && div.req && div.frac && !mag_big
		&& div.quotient >= FRAC_Q_MIN && div.quotient <= FRAC_Q_MAX |=> !div.ovf && div.done)
		else $error("fractional quotient in range flagged as overflow");
	a_frac_mag_ovf: assert property (ce_i && div.req && div.frac && mag_big
		|=> div.ovf)
		else $error("dividend above divisor not flagged");
	a_int_range: assert property (ce_i && div.req && !div.frac
		|=> div.ovf == ($past(div.quotient) > INT_Q_MAX || $past(div.quotient) < INT_Q_MIN))
		else $error("integer quotient range verdict wrong");
	a_div_verdict: assert property (ce_i && div.req |=> div.done ##1 (ce_i || $stable(div.ovf)))
		else $error("division verdict missing");

	c_frac_ovf: cover property (ce_i && div.req && div.frac ##1 div.ovf);
	c_int_ok: cover property (ce_i && div.req && !div.frac ##1 !div.ovf);

endmodule : ald_div_range

// ### bench/tb_ald_alu_logic.sv
// self-checking bench for the alu logic and division range block
`timescale 1ns/100ps
module tb_ald_alu_logic;
	import ald_pkg::*;

	logic                     mclk_i, arst_n_i, ce_i, ld_valid_i, op_valid_i, op_long_i;
	logic                     op_dst_b_i, op_done_o, op_illegal_o, div_req_i, div_frac_i;
	logic                     div_done_o, div_ovf_o, en;
	ald_ld_e                  ld_sel_i;
	ald_lop_e                 op_code_i;
	ald_src_e                 op_src_i;
	logic [ACC_W-1:0]         ld_data_i, acc_a_o, acc_b_o, ma, mb;
	logic [WORD_W-1:0]        data_reg_x_low_o, data_reg_y_low_o, data_reg_y_high_o;
	logic [WORD_W-1:0]        mx, myl, myh;
	logic signed [DVD_W-1:0]  div_dividend_i;
	logic signed [WORD_W-1:0] div_divisor_i;
	logic signed [QUO_W-1:0]  div_quotient_i;
	logic [31:0]              seed;
	logic [72:0]              e;
	logic [72:0]              opq[$];
	logic                     divq[$];
	int                       err_count, compares;

	ald_alu_logic ald_alu_logic_inst (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
		.ld_valid_i(ld_valid_i), .ld_sel_i(ld_sel_i), .ld_data_i(ld_data_i),
		.op_valid_i(op_valid_i), .op_code_i(op_code_i), .op_long_i(op_long_i),
		.op_src_i(op_src_i), .op_dst_b_i(op_dst_b_i), .op_done_o(op_done_o),
		.op_illegal_o(op_illegal_o), .acc_a_o(acc_a_o), .acc_b_o(acc_b_o),
		.data_reg_x_low_o(data_reg_x_low_o), .data_reg_y_low_o(data_reg_y_low_o),
		.data_reg_y_high_o(data_reg_y_high_o), .div_req_i(div_req_i),
		.div_frac_i(div_frac_i), .div_dividend_i(div_dividend_i),
		.div_divisor_i(div_divisor_i), .div_quotient_i(div_quotient_i),
		.div_done_o(div_done_o), .div_ovf_o(div_ovf_o));

	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input logic [72:0] seen, input logic [72:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done

	task automatic reset_look;
		check({acc_a_o, acc_b_o}, 73'h0);
		check({op_done_o, op_illegal_o, div_done_o, div_ovf_o}, 73'h0);
		check({data_reg_x_low_o, data_reg_y_low_o, data_reg_y_high_o}, 73'h0);
	endtask : reset_look

	task automatic idle;
		@(posedge mclk_i);
		ld_valid_i <= 1'b0;
		op_valid_i <= 1'b0;
		div_req_i  <= 1'b0;
	endtask : idle

	task automatic drain;
		int n;
		for (n = 0; n < 20 && (opq.size() > 0 || divq.size() > 0); n++)
			@(posedge mclk_i);
		if (opq.size() > 0 || divq.size() > 0) begin
			err_count++;
			test_done;
		end
	endtask : drain

	task automatic load(input ald_ld_e s, input logic [35:0] d);
		@(posedge mclk_i);
		op_valid_i <= 1'b0;
		ld_valid_i <= 1'b1;
		ld_sel_i   <= s;
		ld_data_i  <= d;
		case (s)
			LD_X_LOW:  mx = d[15:0];
			LD_Y_LOW:  myl = d[15:0];
			LD_Y_HIGH: myh = d[15:0];
			LD_ACC_A:  ma = d;
			default:   mb = d;
		endcase
	endtask : load

	// a load rides along with every op and must be ignored
	task automatic op(input ald_lop_e c, input logic lg, input ald_src_e s, input logic db);
		logic [35:0] d;
		logic [35:0] o;
		logic [31:0] v;
		logic [31:0] w;
		logic        ill;
		@(posedge mclk_i);
		op_valid_i <= 1'b1;
		op_code_i  <= c;
		op_long_i  <= lg;
		op_src_i   <= s;
		op_dst_b_i <= db;
		ld_valid_i <= 1'b1;
		ld_sel_i   <= db ? LD_ACC_A : LD_ACC_B;
		ld_data_i  <= {4'h5, seed};
		d = db ? mb : ma;
		o = db ? ma : mb;
		ill = lg ? (c == LOP_NOT || s inside {SRC_X_LOW, SRC_Y_LOW, SRC_Y_HIGH})
			: (s == SRC_Y_PAIR);
		case (s)
			SRC_X_LOW:  v = {16'h0000, mx};
			SRC_Y_LOW:  v = {16'h0000, myl};
			SRC_Y_HIGH: v = {16'h0000, myh};
			SRC_Y_PAIR: v = {myh, myl};
			default:    v = lg ? o[31:0] : {16'h0000, o[31:16]};
		endcase
		w = lg ? d[31:0] : {16'h0000, d[31:16]};
		case (c)
			LOP_AND: w = w & v;
			LOP_OR:  w = w | v;
			LOP_XOR: w = w ^ v;
			default: w = ~w;
		endcase
		if (lg)
			d[31:0] = w;
		else
			d[31:16] = w[15:0];
		if (en && !ill) begin
			if (db)
				mb = d;
			else
				ma = d;
		end
		if (en)
			opq.push_back({ill, ma, mb});
	endtask : op

	task automatic div(input logic f, input logic [31:0] dd, input logic [15:0] dv,
		input logic [35:0] q);
		longint a;
		longint b;
		longint qq;
		@(posedge mclk_i);
		div_req_i      <= 1'b1;
		div_frac_i     <= f;
		div_dividend_i <= dd;
		div_divisor_i  <= dv;
		div_quotient_i <= q;
		qq = $signed(q);
		a = $signed(dd);
		b = $signed(dv);
		a = a < 0 ? -a : a;
		b = (b < 0 ? -b : b) * 65536;
		if (en)
			divq.push_back(f ? (qq < -32768 || qq > 32766 || a > b)
				: (qq < -32768 || qq > 32767));
	endtask : div

	always @(posedge mclk_i) begin
		#1;
		if (op_done_o === 1'b1 || op_illegal_o === 1'b1) begin
			e = opq.size() > 0 ? opq.pop_front() : '1;
			check({op_illegal_o, acc_a_o, acc_b_o}, e);
			check(op_done_o, !e[72]);
		end
		if (div_done_o === 1'b1)
			check(div_ovf_o, divq.size() > 0 ? divq.pop_front() : 1'bx);
	end

	initial begin
		{arst_n_i, ld_valid_i, op_valid_i, op_long_i, op_dst_b_i, div_req_i, div_frac_i} = '0;
		{ld_data_i, div_dividend_i, div_divisor_i, div_quotient_i} = '0;
		{ma, mb, mx, myl, myh} = '0;
		ld_sel_i = LD_X_LOW;
		op_code_i = LOP_AND;
		op_src_i = SRC_X_LOW;
		ce_i = 1'b1;
		en = 1'b1;
		seed = 32'he9da_fe3d;
		repeat (5) @(posedge mclk_i);
		arst_n_i <= 1'b1;
		reset_look;
		load(LD_ACC_A, 36'h9_1234_5678);
		load(LD_ACC_B, 36'h6_8765_4321);
		load(LD_X_LOW, 36'h0_0000_F0F0);
		load(LD_Y_LOW, 36'h0_0000_00FF);
		load(LD_Y_HIGH, 36'h0_0000_A5A5);
		idle;
		@(posedge mclk_i);
		check({data_reg_x_low_o, data_reg_y_low_o, data_reg_y_high_o}, {mx, myl, myh});
		$display("test loads done");
		for (int i = 0; i < 80; i++)
			op(ald_lop_e'(i[1:0]), i[2], ald_src_e'(3'(i / 16)), i[3]);
		idle;
		drain;
		$display("test op table done");
		repeat (200) begin
			seed = lfsr(lfsr(seed));
			if (seed[0])
				load(ald_ld_e'(3'(seed[10:3] % 5)), {seed[7:4], lfsr(seed)});
			else
				op(ald_lop_e'(seed[2:1]), seed[3], ald_src_e'(3'(seed[11:4] % 5)), seed[5]);
		end
		idle;
		drain;
		@(negedge mclk_i);
		check({data_reg_x_low_o, data_reg_y_low_o, data_reg_y_high_o}, {mx, myl, myh});
		$display("test random ops done");
		div(1'b1, 32'h0000_0000, 16'h4000, -36'sd32768);
		div(1'b1, 32'h0000_0000, 16'h4000, -36'sd32769);
		div(1'b1, 32'h0000_0000, 16'h4000, 36'sd32766);
		div(1'b1, 32'h0000_0000, 16'h4000, 36'sd32767);
		div(1'b1, 32'h4000_0000, 16'h2000, 36'sd0);
		div(1'b1, 32'h2000_0000, 16'h2000, 36'sd0);
		div(1'b1, 32'hC000_0000, 16'hE000, 36'sd0);
		div(1'b0, 32'h7FFF_0000, 16'h0001, 36'sd32767);
		div(1'b0, 32'h7FFF_0000, 16'h0001, 36'sd32768);
		div(1'b0, 32'h7FFF_0000, 16'h0001, -36'sd32768);
		div(1'b0, 32'h7FFF_0000, 16'h0001, -36'sd32769);
		repeat (40) begin
			seed = lfsr(lfsr(seed));
			div(seed[0], lfsr(seed), seed[31:16], 36'($signed(seed[17:0])));
		end
		idle;
		drain;
		$display("test division range done");
		@(posedge mclk_i);
		ce_i <= 1'b0;
		en = 1'b0;
		op(LOP_NOT, 1'b0, SRC_X_LOW, 1'b0);
		div(1'b0, 32'h0, 16'h1, 36'sd40000);
		idle;
		@(posedge mclk_i);
		ce_i <= 1'b1;
		en = 1'b1;
		op(LOP_OR, 1'b1, SRC_ACC_OTHER, 1'b1);
		idle;
		drain;
		$display("test clock enable done");
		// reset in mid-run clears every register and pulse
		@(posedge mclk_i);
		arst_n_i <= 1'b0;
		{ma, mb, mx, myl, myh} = '0;
		repeat (2) @(posedge mclk_i);
		reset_look;
		arst_n_i <= 1'b1;
		op(LOP_NOT, 1'b0, SRC_X_LOW, 1'b0);
		idle;
		drain;
		$display("test mid-run reset done");
		test_done;
	end

endmodule : tb_ald_alu_logic
